// File: inc/motion_map.svh
// register offsets, field positions, codes and timing counts of the motion-event engine
`ifndef MOTION_MAP_SVH
`define MOTION_MAP_SVH

// device registers as seen over the serial link (7-bit addresses)
`define A_STAGE_BASE   7'h00
`define A_STAGE_LAST   7'h07
`define A_CMD          7'h08
`define A_SENS         7'h09
`define A_FEAT         7'h0A
`define A_EVT          7'h0B
`define A_STEP_LO      7'h0C
`define A_STEP_MID     7'h0D
`define A_STEP_HI      7'h0E
`define A_CMD_STAT     7'h0F

// command codes and pass markers
`define CMD_PED_CFG    8'h0D
`define CMD_PED_RST    8'h0F
`define CMD_WAKE       8'h08
`define PASS_ONE       8'h01
`define PASS_TWO       8'h02

// field positions
`define SENS_ACCEL     0
`define SENS_GYRO      1
`define FEAT_PED_EN    4
`define FEAT_ROUTE     6
`define EVT_PED        4
`define EVT_WAKE       2
`define WAKE_LEVEL     7
`define WAKE_PIN       6

// reset value of every device register
`define REG_RESET      8'h00

// link framing: read flag, 7 address bits, 8 data bits
`define FRAME_LAST     5'd15
`define ADDR_LAST      5'd7
`define DATA_FIRST     5'd8

// controller registers on the AHB-Lite side (byte offsets)
`define HOFF_CMD       8'h00
`define HOFF_STAT      8'h04
`define HCMD_RD_BIT    16

// ref clock cycles per half link clock period
`define LINK_HALF_CYCLES 8

`endif

// File: inc/motion_pkg.sv
// types shared by both ends of the motion-event link
package motion_pkg;

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_SHIFT = 2'b01,
    H_GAP   = 2'b10
  } host_state_t;

  // complete state of the device end
  typedef struct packed {
    logic [2:0]      clk_s;
    logic [1:0]      sel_s;
    logic [1:0]      mosi_s;
    logic [4:0]      bit_cnt;
    logic [15:0]     in_sh;
    logic [7:0]      out_sh;
    logic            miso;
    logic [7:0][7:0] stage;
    logic [7:0]      cmd;
    logic [7:0]      sens;
    logic [7:0]      feat;
    logic            ped_flag;
    logic            wake_flag;
    logic            cmd_done;
    logic [15:0]     window;
    logic [15:0]     swing;
    logic [15:0]     peak;
    logic [15:0]     timeout;
    logic [7:0]      min_time;
    logic [7:0]      entry;
    logic [7:0]      precision;
    logic [7:0]      upd;
    logic [23:0]     steps;
    logic [7:0]      since;
    logic            ped_pend;
    logic            ped_pin;
    logic [7:0]      wake_thr;
    logic [1:0]      wake_sel;
    logic [5:0]      blank;
    logic            wake_line;
    logic            pin_one;
    logic            pin_two;
  } dev_state_t;

  // complete state of the controller end
  typedef struct packed {
    host_state_t st;
    logic        ap_valid;
    logic        ap_write;
    logic [7:0]  ap_off;
    logic [31:0] hrdata;
    logic [7:0]  div;
    logic [4:0]  bits;
    logic        link_clk;
    logic        sel_n;
    logic        mosi;
    logic [15:0] tx;
    logic [7:0]  rx;
    logic [7:0]  rdata;
    logic [1:0]  miso_s;
    logic [1:0]  i1_s;
    logic [1:0]  i2_s;
  } host_st_t;

endpackage

// File: inc/motion_link_if.sv
// serial register link and interrupt pins between controller and device
`timescale 1ns/1ps
interface motion_link_if;
  logic link_clk;
  logic sel_n;
  logic mosi;
  logic miso;
  logic interrupt_pin_one;
  logic interrupt_pin_two;

  modport ctrl (
    output link_clk,
    output sel_n,
    output mosi,
    input  miso,
    input  interrupt_pin_one,
    input  interrupt_pin_two
  );

  modport dev (
    input  link_clk,
    input  sel_n,
    input  mosi,
    output miso,
    output interrupt_pin_one,
    output interrupt_pin_two
  );
endinterface

// File: verilog/motion_dev.sv
// device end: staging registers, command engine, step counter and motion wake
//
// Behaviour
// - pedometer load is two 0x0D passes, marker 1/2
// - host stages pass-specific parameter pairs beforehand
// - host loads parameters with sensors disabled
// - steps counted when pedometer and accel enabled
// - counting halts if either enable clears
// - one event per update-count steps
// - pedometer event sets status bit 4
// - route bit 6 picks pin one or two
// - pedometer pin pulse aligned to data ready
// - 24-bit total advances by update count
// - total wraps to zero past maximum
// - total clears on reset, enable rise, 0x0F
// - accel enable changes keep the total
// - command 0x08 sets threshold; zero disables
// - select field picks pin and start level
// - blanking count skips samples after enabling
// - motion wake sets status bit 2
// - status read clears flag, restores level
// - each wake event toggles the pin
// - wake mode persists until reprogrammed
// - nonzero threshold clears flag, sets pin
// - host exits wake with sensors off first
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "motion_map.svh"
module motion_dev
  import motion_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  motion_link_if.dev       lk,
  input  wire logic        sample_tick_i,
  input  wire logic        step_i,
  input  wire logic [7:0]  slope_i,
  output logic             step_run_o,
  output logic             accel_en_o,
  output logic             gyro_en_o,
  output logic [15:0]      ped_window_o,
  output logic [15:0]      ped_swing_o,
  output logic [15:0]      ped_peak_o,
  output logic [15:0]      ped_timeout_o,
  output logic [7:0]       ped_min_time_o,
  output logic [7:0]       ped_entry_o,
  output logic [7:0]       ped_precision_o,
  output logic [7:0]       ped_update_o
);

  dev_state_t r;
  dev_state_t n;

  // next-state logic for the whole device
  always_comb
  begin
    logic        rise;
    logic        fall;
    logic        evt_rd;
    logic        stat_rd;
    logic        wr;
    logic        run;
    logic        wake_on;
    logic [15:0] sh;
    logic [6:0]  addr;
    logic [7:0]  data;
    logic [7:0]  rv;
    logic [7:0]  upd_eff;
    n       = r;
    rise    = 1'b0;
    fall    = 1'b0;
    evt_rd  = 1'b0;
    stat_rd = 1'b0;
    wr      = 1'b0;
    sh      = {r.in_sh[14:0], r.mosi_s[1]};
    addr    = sh[14:8];
    data    = sh[7:0];
    rv      = 8'h00;
    run     = r.feat[`FEAT_PED_EN] & r.sens[`SENS_ACCEL];
    wake_on = (r.wake_thr != 8'h00);
    upd_eff = (r.upd == 8'h00) ? 8'h01 : r.upd;

    // pin synchronisers; edges are judged on the second and third stages only
    n.clk_s  = {r.clk_s[1:0], lk.link_clk};
    n.sel_s  = {r.sel_s[0], lk.sel_n};
    n.mosi_s = {r.mosi_s[0], lk.mosi};
    rise     = r.clk_s[1] & ~r.clk_s[2];
    fall     = ~r.clk_s[1] & r.clk_s[2];

    // read data chosen from the address just shifted in
    case (sh[6:0])
      `A_CMD:      rv = r.cmd;
      `A_SENS:     rv = r.sens;
      `A_FEAT:     rv = r.feat;
      `A_EVT:      rv = {3'b000, r.ped_flag, 1'b0, r.wake_flag, 2'b00};
      `A_STEP_LO:  rv = r.steps[7:0];
      `A_STEP_MID: rv = r.steps[15:8];
      `A_STEP_HI:  rv = r.steps[23:16];
      `A_CMD_STAT: rv = {7'h00, r.cmd_done};
      default:     rv = (sh[6:0] <= `A_STAGE_LAST) ? r.stage[sh[2:0]] : 8'h00;
    endcase

    // link framing: select high aborts; sample on rise, shift out on fall
    if (r.sel_s[1])
    begin
      n.bit_cnt = 5'd0;
      n.miso    = 1'b0;
    end
    else if (rise)
    begin
      n.in_sh   = sh;
      n.bit_cnt = r.bit_cnt + 5'd1;
      if (r.bit_cnt == `ADDR_LAST)
      begin
        n.out_sh = rv;
        evt_rd   = sh[7] && (sh[6:0] == `A_EVT);
        stat_rd  = sh[7] && (sh[6:0] == `A_CMD_STAT);
      end
      wr = (r.bit_cnt == `FRAME_LAST) && !sh[15];
    end
    else if (fall && (r.bit_cnt >= `DATA_FIRST))
    begin
      n.miso   = r.out_sh[7];
      n.out_sh = {r.out_sh[6:0], 1'b0};
    end

    // clears first, so that hardware sets below win in the same cycle
    if (evt_rd)
    begin
      n.wake_flag = 1'b0;
      n.ped_flag  = 1'b0;
      n.wake_line = r.wake_sel[1];
    end
    if (stat_rd)
      n.cmd_done = 1'b0;

    // register writes and command execution
    if (wr)
    begin
      case (addr)
        `A_CMD:
        begin
          n.cmd      = data;
          n.cmd_done = 1'b1;
          case (data)
            `CMD_PED_CFG:
            begin
              if (r.stage[7] == `PASS_ONE)
              begin
                n.window = {r.stage[1], r.stage[0]};
                n.swing  = {r.stage[3], r.stage[2]};
                n.peak   = {r.stage[5], r.stage[4]};
              end
              else if (r.stage[7] == `PASS_TWO)
              begin
                n.timeout   = {r.stage[1], r.stage[0]};
                n.min_time  = r.stage[2];
                n.entry     = r.stage[3];
                n.precision = r.stage[4];
                n.upd       = r.stage[5];
              end
            end
            `CMD_PED_RST:
            begin
              n.steps = 24'h000000;
              n.since = 8'h00;
            end
            `CMD_WAKE:
            begin
              n.wake_thr = r.stage[0];
              n.wake_sel = r.stage[1][`WAKE_LEVEL:`WAKE_PIN];
              n.blank    = r.stage[1][5:0];
              if (r.stage[0] != 8'h00)
              begin
                n.wake_flag = 1'b0;
                n.wake_line = r.stage[1][`WAKE_LEVEL];
              end
            end
            default:
            begin
              n.cmd = data;                            // unknown codes only complete
            end
          endcase
        end
        `A_SENS: n.sens = data;
        `A_FEAT:
        begin
          n.feat = data;
          if (!r.feat[`FEAT_PED_EN] && data[`FEAT_PED_EN])
          begin
            n.steps = 24'h000000;
            n.since = 8'h00;
          end
        end
        default:
        begin
          if (addr <= `A_STAGE_LAST)
            n.stage[addr[2:0]] = data;
        end
      endcase
    end

    // data-ready tick: pedometer pin follows the pending event for one sample
    if (sample_tick_i)
    begin
      n.ped_pin  = r.ped_pend;
      n.ped_pend = 1'b0;
      // wake detection sees only accelerometer samples
      if (wake_on && r.sens[`SENS_ACCEL])
      begin
        if (r.blank != 6'd0)
          n.blank = r.blank - 6'd1;
        else if (slope_i > r.wake_thr)
        begin
          n.wake_flag = 1'b1;
          n.wake_line = ~n.wake_line;
        end
      end
    end

    // step counting; the total only moves in whole update counts
    if (run && step_i)
    begin
      if ((r.since + 8'd1) >= upd_eff)
      begin
        n.steps    = n.steps + {16'h0000, upd_eff};
        n.since    = 8'h00;
        n.ped_pend = 1'b1;
        n.ped_flag = 1'b1;
      end
      else
        n.since = r.since + 8'd1;
    end

    // pins: wake mode owns its selected pin, the other keeps pedometer routing
    n.pin_one = (wake_on && !r.wake_sel[0]) ? r.wake_line : (r.feat[`FEAT_ROUTE] & r.ped_pin);
    n.pin_two = (wake_on && r.wake_sel[0]) ? r.wake_line : (~r.feat[`FEAT_ROUTE] & r.ped_pin);
  end

  // single state register; reset clears the total with everything else
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      r <= '0;
    else
      r <= n;
  end

  // outputs straight from state
  assign lk.miso              = r.miso;
  assign lk.interrupt_pin_one = r.pin_one;
  assign lk.interrupt_pin_two = r.pin_two;
  assign step_run_o           = r.feat[`FEAT_PED_EN] & r.sens[`SENS_ACCEL];
  assign accel_en_o           = r.sens[`SENS_ACCEL];
  assign gyro_en_o            = r.sens[`SENS_GYRO];
  assign ped_window_o         = r.window;
  assign ped_swing_o          = r.swing;
  assign ped_peak_o           = r.peak;
  assign ped_timeout_o        = r.timeout;
  assign ped_min_time_o       = r.min_time;
  assign ped_entry_o          = r.entry;
  assign ped_precision_o      = r.precision;
  assign ped_update_o         = r.upd;

endmodule // motion_dev

// File: verilog/motion_ctrl.sv
// controller end: AHB-Lite slave that runs register frames over the serial link
`timescale 1ns/1ps
`include "motion_map.svh"
module motion_ctrl
  import motion_pkg::*;
#(
  parameter int unsigned LINK_HALF = `LINK_HALF_CYCLES
)
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  motion_link_if.ctrl      lk
);

  host_st_t r;
  host_st_t n;

  // next-state logic for bus slave and link engine
  always_comb
  begin
    logic busy;
    n    = r;
    busy = (r.st != H_IDLE);

    // pin synchronisers
    n.miso_s = {r.miso_s[0], lk.miso};
    n.i1_s   = {r.i1_s[0], lk.interrupt_pin_one};
    n.i2_s   = {r.i2_s[0], lk.interrupt_pin_two};

    // address phase; read data is prepared here so it stands in the data phase
    n.ap_valid = hsel_i & htrans_i[1] & hready_i;
    n.ap_write = hwrite_i;
    n.ap_off   = haddr_i[7:0];
    n.hrdata   = 32'h00000000;
    if (hsel_i && htrans_i[1] && hready_i && !hwrite_i && (haddr_i[7:0] == `HOFF_STAT))
      n.hrdata = {14'h0000, r.i2_s[1], r.i1_s[1], r.rdata, 7'h00, busy};

    // link engine: the controller makes the link clock by dividing its own
    case (r.st)
      H_IDLE:
      begin
        // software sequences parameter passes and wake exit through these frames
        if (r.ap_valid && r.ap_write && (r.ap_off == `HOFF_CMD))
        begin
          n.tx       = {hwdata_i[`HCMD_RD_BIT], hwdata_i[14:0]};
          n.mosi     = hwdata_i[`HCMD_RD_BIT];
          n.sel_n    = 1'b0;
          n.link_clk = 1'b0;
          n.div      = 8'h00;
          n.bits     = 5'd0;
          n.st       = H_SHIFT;
        end
      end
      H_SHIFT:
      begin
        if (r.div == 8'(LINK_HALF - 1))
        begin
          n.div = 8'h00;
          if (!r.link_clk)
            n.link_clk = 1'b1;
          else
          begin
            // sample at the end of the high phase, well after the device shifted
            n.link_clk = 1'b0;
            n.rx       = {r.rx[6:0], r.miso_s[1]};
            if (r.bits == `FRAME_LAST)
            begin
              n.rdata = {r.rx[6:0], r.miso_s[1]};
              n.sel_n = 1'b1;
              n.st    = H_GAP;
            end
            else
            begin
              n.bits = r.bits + 5'd1;
              n.tx   = {r.tx[14:0], 1'b0};
              n.mosi = r.tx[14];
            end
          end
        end
        else
          n.div = r.div + 8'h01;
      end
      H_GAP:
      begin
        // select stays high a half period so the device sees the frame end
        if (r.div == 8'(LINK_HALF - 1))
        begin
          n.div = 8'h00;
          n.st  = H_IDLE;
        end
        else
          n.div = r.div + 8'h01;
      end
      default:
      begin
        n.st    = H_IDLE;
        n.sel_n = 1'b1;
      end
    endcase
  end

  // single state register; select idles high
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r       <= '0;
      r.sel_n <= 1'b1;
    end
    else
      r <= n;
  end

  assign hrdata_o    = r.hrdata;
  assign hreadyout_o = 1'b1;   // zero wait states; busy shows in status instead
  assign hresp_o     = 1'b0;
  assign lk.link_clk = r.link_clk;
  assign lk.sel_n    = r.sel_n;
  assign lk.mosi     = r.mosi;

endmodule // motion_ctrl

// File: verification/motion_link_properties.sv
// concurrent checks on the serial link and interrupt pins between the two ends
`timescale 1ns/1ps
module motion_link_properties (
  input logic ref_clk_i,
  input logic rst_i,
  input logic link_clk_i,
  input logic sel_n_i,
  input logic mosi_i,
  input logic miso_i,
  input logic pin_one_i,
  input logic pin_two_i,
  input logic sample_tick_i
);
  logic [4:0] rises_r;
  logic       lclk_r;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  // counts link clock rises inside one frame; cleared while deselected
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rises_r <= 5'h00;
      lclk_r  <= 1'b0;
    end
    else
    begin
      lclk_r <= link_clk_i;
      if (sel_n_i)
        rises_r <= 5'h00;
      else if (link_clk_i && !lclk_r)
        rises_r <= rises_r + 5'h01;
    end
  end

  // the link clock stands low between frames so a stray edge is never sampled
  a_clk_idle_low: assert property (sel_n_i |-> !link_clk_i)
    else $error("link clock high while deselected");
  a_clk_high_half: assert property ($rose(link_clk_i) |-> link_clk_i [*8] ##1 !link_clk_i)
    else $error("link clock high phase not eight cycles");
  a_clk_low_half: assert property ($fell(link_clk_i) && !sel_n_i |-> (!link_clk_i) [*8] ##1 link_clk_i)
    else $error("link clock low phase not eight cycles");
  a_first_rise_delay: assert property ($fell(sel_n_i) |-> (!link_clk_i) [*6] ##[1:3] link_clk_i)
    else $error("first link clock rise misplaced");
  a_mosi_stable_high: assert property (link_clk_i && $past(link_clk_i) |-> $stable(mosi_i))
    else $error("mosi moved while link clock high");
  a_sel_gap_held: assert property ($rose(sel_n_i) |-> sel_n_i [*6])
    else $error("frame gap too short");
  a_frame_sixteen_rises: assert property ($rose(sel_n_i) |-> rises_r == 5'd16)
    else $error("frame did not carry sixteen bits");
  a_miso_low_phase: assert property ($changed(miso_i) |-> !link_clk_i)
    else $error("miso moved while link clock high");
  // outside frames the pins only move a fixed time after a data-ready pulse
  a_pin_on_tick: assert property ($changed({pin_one_i, pin_two_i}) && sel_n_i && $past(sel_n_i, 8)
    |-> $past(sample_tick_i, 2) || $past(sample_tick_i, 3))
    else $error("interrupt pin moved away from data ready");
endmodule // motion_link_properties

// File: verification/test_step_counter_and_wake_on_motion.sv
// self-checking bench: AHB-Lite controller, serial link and device end together
`timescale 1ns/1ps
`include "motion_map.svh"
module test_step_counter_and_wake_on_motion;
  import motion_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [31:0] hwdata    = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        gyro;
  logic [2:0]  hsize     = 3'h0;
  logic        tick      = 1'b0;
  logic        step      = 1'b0;
  logic [7:0]  slope     = 8'h00;
  logic        step_run;
  logic        accel_en;
  logic [15:0] win, swing, peak, tmo;
  logic [7:0]  min_t, entry, prec, upd, v;
  logic [31:0] st;
  logic [7:0]  p1 [6] = '{8'h32, 8'h00, 8'hCC, 8'h00, 8'h66, 8'h00};
  logic [7:0]  p2 [6] = '{8'hC8, 8'h00, 8'h14, 8'h0A, 8'h00, 8'h04};
  int          n_fail      = 0;
  int          comparisons = 0;
  int          cycles      = 0;

  motion_link_if lk ();
  motion_ctrl i_motion_ctrl (
    .ref_clk_i (ref_clk_i), .rst_i (rst_i), .hsel_i (hsel), .haddr_i (haddr), .htrans_i (htrans),
    .hwrite_i (hwrite), .hsize_i (hsize), .hwdata_i (hwdata), .hready_i (hready), .hrdata_o (hrdata),
    .hreadyout_o (hready), .hresp_o (hresp), .lk (lk));
  motion_dev i_motion_dev (
    .ref_clk_i (ref_clk_i), .rst_i (rst_i), .lk (lk), .sample_tick_i (tick), .step_i (step), .slope_i (slope),
    .step_run_o (step_run), .accel_en_o (accel_en), .gyro_en_o (gyro), .ped_window_o (win), .ped_swing_o (swing),
    .ped_peak_o (peak), .ped_timeout_o (tmo), .ped_min_time_o (min_t), .ped_entry_o (entry),
    .ped_precision_o (prec), .ped_update_o (upd));
  motion_link_properties i_motion_link_properties (
    .ref_clk_i (ref_clk_i), .rst_i (rst_i), .link_clk_i (lk.link_clk), .sel_n_i (lk.sel_n), .mosi_i (lk.mosi),
    .miso_i (lk.miso), .pin_one_i (lk.interrupt_pin_one), .pin_two_i (lk.interrupt_pin_two),
    .sample_tick_i (tick));

  always #12.5 ref_clk_i = ~ref_clk_i;

  // a hang counts as a mismatch and ends the run
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      n_fail++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // single transfer; read data taken at the edge that closes the data phase
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge ref_clk_i); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge ref_clk_i); while (hready !== 1'b1);
    r = hrdata;
  endtask

  // one device frame: post the command word, then poll busy until clear
  task automatic dev(input logic rd, input logic [6:0] a, input logic [7:0] d);
    int n;
    ahb(1'b1, {24'h0, `HOFF_CMD}, {15'h0, rd, 1'b0, a, d}, st);
    repeat (2) @(posedge ref_clk_i);
    n  = 0;
    st = 32'h1;
    while (st[0] !== 1'b0 && n < 2000)
    begin
      ahb(1'b0, {24'h0, `HOFF_STAT}, 32'h0, st);
      n++;
    end
    v = st[15:8];
    // a frame that never finishes is a mismatch and ends the run
    if (st[0] !== 1'b0)
    begin
      n_fail++;
      $display("unexpected busy: expected 0, seen 1");
      stop_test();
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    dev(1'b0, a, d);
  endtask

  task automatic rdchk(input string what, input logic [6:0] a, input logic [7:0] exp);
    dev(1'b1, a, 8'h00);
    chk(what, {24'h0, exp}, {24'h0, v});
  endtask

  task automatic stp(input int n);
    repeat (n)
    begin
      step <= 1'b1;
      @(posedge ref_clk_i);
      step <= 1'b0;
      @(posedge ref_clk_i);
    end
  endtask

  // data-ready pulse with a slope sample; waits for the pins to settle
  task automatic tk(input logic [7:0] sl);
    tick  <= 1'b1;
    slope <= sl;
    @(posedge ref_clk_i);
    tick <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
  endtask

  function automatic logic wpin(input logic two);
    return two ? lk.interrupt_pin_two : lk.interrupt_pin_one;
  endfunction

  // main sequence: reset state, pedometer load and counting, motion wake
  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    rdchk("event status", `A_EVT, 8'h00);
    rdchk("total low", `A_STEP_LO, 8'h00);
    ahb(1'b0, 32'h0000_0010, 32'h0, st);
    chk("unmapped read", 32'h0, st);
    chk("response", 32'h0, {31'h0, hresp});
    for (int i = 0; i < 8; i++) wr(i[6:0], 8'hA0 + i[7:0]);
    for (int i = 0; i < 8; i++) rdchk("stage", i[6:0], 8'hA0 + i[7:0]);
    wr(`A_CMD, `CMD_PED_CFG);
    chk("window", 16'h0, win);
    for (int i = 0; i < 6; i++) wr(i[6:0], p1[i]);
    wr(7'h07, `PASS_ONE);
    wr(`A_CMD, `CMD_PED_CFG);
    chk("window", 16'h0032, win);
    chk("swing", 16'h00CC, swing);
    chk("peak", 16'h0066, peak);
    for (int i = 0; i < 6; i++) wr(i[6:0], p2[i]);
    chk("window", 16'h0032, win);
    wr(7'h07, `PASS_TWO);
    wr(`A_CMD, `CMD_PED_CFG);
    chk("timeout", 16'h00C8, tmo);
    chk("min time", 8'h14, min_t);
    chk("entry", 8'h0A, entry);
    chk("precision", 8'h00, prec);
    chk("update", 8'h04, upd);
    chk("window", 16'h0032, win);
    rdchk("done", `A_CMD_STAT, 8'h01);
    rdchk("done", `A_CMD_STAT, 8'h00);
    wr(`A_SENS, 8'h01);
    wr(`A_FEAT, 8'h50);
    chk("step run", 1'b1, step_run);
    chk("accel enable", 1'b1, accel_en);
    rdchk("features", `A_FEAT, 8'h50);
    rdchk("sensors", `A_SENS, 8'h01);
    stp(3);
    tk(8'h00);
    chk("pin one", 1'b0, lk.interrupt_pin_one);
    stp(1);
    chk("pin one", 1'b0, lk.interrupt_pin_one);
    tk(8'h00);
    chk("pin one", 1'b1, lk.interrupt_pin_one);
    chk("pin two", 1'b0, lk.interrupt_pin_two);
    ahb(1'b0, {24'h0, `HOFF_STAT}, 32'h0, st);
    chk("status pins", 32'h1, {30'h0, st[17:16]});
    rdchk("event status", `A_EVT, 8'h10);
    rdchk("total low", `A_STEP_LO, 8'h04);
    rdchk("total middle", `A_STEP_MID, 8'h00);
    rdchk("total high", `A_STEP_HI, 8'h00);
    tk(8'h00);
    chk("pin one", 1'b0, lk.interrupt_pin_one);
    wr(`A_SENS, 8'h00);
    chk("step run", 1'b0, step_run);
    stp(4);
    wr(`A_SENS, 8'h01);
    rdchk("total low", `A_STEP_LO, 8'h04);
    wr(`A_FEAT, 8'h00);
    wr(`A_FEAT, 8'h10);
    rdchk("total low", `A_STEP_LO, 8'h00);
    stp(4);
    tk(8'h00);
    chk("pin two", 1'b1, lk.interrupt_pin_two);
    rdchk("total low", `A_STEP_LO, 8'h04);
    wr(`A_CMD, `CMD_PED_RST);
    rdchk("command", `A_CMD, `CMD_PED_RST);
    rdchk("total low", `A_STEP_LO, 8'h00);
    rdchk("event status", `A_EVT, 8'h10);
    tk(8'h00);
    wr(`A_FEAT, 8'h00);
    // every pin select code: start level, one toggle, restore on status read
    for (int s = 0; s < 4; s++)
    begin
      wr(7'h00, 8'h10);
      wr(7'h01, {s[1:0], 6'h00});
      wr(`A_CMD, `CMD_WAKE);
      chk("wake pin", s[1], wpin(s[0]));
      chk("other pin", 1'b0, wpin(!s[0]));
      tk(8'h11);
      chk("wake pin", !s[1], wpin(s[0]));
      rdchk("event status", `A_EVT, 8'h04);
      chk("wake pin", s[1], wpin(s[0]));
    end
    tk(8'h11);
    wr(7'h00, 8'h10);
    wr(7'h01, 8'h82);
    wr(`A_CMD, `CMD_WAKE);
    rdchk("event status", `A_EVT, 8'h00);
    chk("pin one", 1'b1, lk.interrupt_pin_one);
    tk(8'h20);
    tk(8'h20);
    chk("pin one", 1'b1, lk.interrupt_pin_one);
    tk(8'h10);
    chk("pin one", 1'b1, lk.interrupt_pin_one);
    tk(8'h11);
    chk("pin one", 1'b0, lk.interrupt_pin_one);
    tk(8'h30);
    chk("pin one", 1'b1, lk.interrupt_pin_one);
    rdchk("event status", `A_EVT, 8'h04);
    wr(`A_SENS, 8'h00);
    wr(7'h00, 8'h00);
    wr(`A_CMD, `CMD_WAKE);
    chk("pin one", 1'b0, lk.interrupt_pin_one);
    wr(`A_SENS, 8'h01);
    tk(8'hFF);
    chk("pin one", 1'b0, lk.interrupt_pin_one);
    rdchk("event status", `A_EVT, 8'h00);
    wr(`A_SENS, 8'h02);
    chk("gyro enable", 1'b1, gyro);
    chk("accel enable", 1'b0, accel_en);
    stop_test();
  end
endmodule // test_step_counter_and_wake_on_motion
